/* crwc_clock_reset_wake.sv */
// Clock selection, oscillator resume delay, wake timer and reset sequencer.
// Function
// - Bit 0 selects external oscillator.
// - External resume waits 4 ms or 128 us.
// - Internal resume waits fixed 8 us.
// - Wake period is base times two-power field.
// - Wake interrupts only while enabled.
// - Undervoltage holds start-up period, restarts zero.
// - Reset entry pushes nothing on stack.
// - Reset clears registers except status register.
// - Reset tri-states pins, disables interrupts, USB.
// - Supply resets force internal clock, wait start-up.
// - Dog reset clears enable; clock kept until suspend.
// - Reset zeroes both stack pointers.
// - Power-up internal clock, undervoltage reset enabled.
// - Disable bit and suspend turn undervoltage off.
// - Sag monitor stays active when undervoltage off.
// - Supply reset flag set on either reset.
// - Sag event re-enables undervoltage, holds reset.
// - Clear write restarts dog; rollover resets.
// - Dog reset sets status bit six.
// - Dog reset held about 2 ms.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module crwc_clock_reset_wake
   import crwc_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = STARTUP_WAIT_CYC,
   parameter int unsigned BASE_WAKE = BASE_WAKE_CYC,
   parameter int unsigned DOG_CYC = DOG_PERIOD_CYC,
   parameter int unsigned DOG_HOLD = DOG_HOLD_CYC,
   parameter int unsigned RES_LONG = RESUME_LONG_CYC,
   parameter int unsigned RES_SHORT = RESUME_SHORT_CYC,
   parameter int unsigned RES_INT = RESUME_INT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   output logic [7:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic undervoltage_i,
   input wire logic supply_sag_i,
   input wire logic suspend_req_i,
   input wire logic wake_event_i,
   input wire logic wake_irq_enable_i,
   output logic wake_irq_o,
   output logic ext_osc_run_o,
   output logic clk_out_disable_o,
   output logic precision_usb_o,
   output logic undervoltage_active_o,
   output logic suspended_o,
   output crwc_core_ctl_s core_ctl_o
);
   initial begin
      if (STARTUP_CYC < 1 || BASE_WAKE < 1 || DOG_CYC < 1 ||
          DOG_HOLD < 1 || RES_LONG < 1 || RES_SHORT < 1 || RES_INT < 1)
         $error("crwc: all cycle counts must be at least one");
      if (BASE_WAKE > 32'h00ffffff)
         $error("crwc: base wake count too large for timer");
   end

   crwc_state_e state;
   logic [7:0] clock_cfg;
   logic [7:0] status_ctrl;
   logic ext_mode;
   logic [31:0] seq_cnt;
   logic [31:0] dog_cnt;
   logic [31:0] wake_cnt;
   logic [31:0] wake_limit;
   logic [31:0] resume_limit;
   logic access;
   logic wr_cfg;
   logic wr_dog;
   logic wr_status;
   logic dog_roll;
   logic uv_enabled;
   logic uv_trip;
   logic supply_reset;
   logic running;

   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_cfg = access && wb_we_i && wb_sel_i &&
                   wb_adr_i == ADDR_CLOCK_CFG;
   assign wr_dog = access && wb_we_i && wb_sel_i &&
                   wb_adr_i == ADDR_WDOG_CLEAR;
   assign wr_status = access && wb_we_i && wb_sel_i &&
                      wb_adr_i == ADDR_STATUS_CTRL;
   assign running = state == ST_RUN;
   assign uv_enabled = !clock_cfg[BIT_UV_DISABLE] && state != ST_SUSPEND;
   assign uv_trip = uv_enabled && undervoltage_i;
   assign supply_reset = supply_sag_i || uv_trip;
   assign dog_roll = running && dog_cnt >= DOG_CYC - 1;
   assign wake_limit = BASE_WAKE << clock_cfg[WAKE_ADJ_LSB +: 3];
   assign resume_limit = (ext_mode || clock_cfg[BIT_EXT_OSC_EN]) ?
      (clock_cfg[BIT_RESUME_LONG] ? RES_LONG : RES_SHORT) : RES_INT;

   // Single-cycle answer; unmapped addresses still acknowledge, reading zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 8'h00;
      end else if (ce_i) begin
         wb_ack_o <= access;
         if (access && !wb_we_i) begin
            case (wb_adr_i)
               ADDR_CLOCK_CFG: wb_dat_o <= clock_cfg;
               ADDR_STATUS_CTRL: wb_dat_o <= status_ctrl;
               default: wb_dat_o <= 8'h00;
            endcase
         end
      end
   end

   // Configuration register; supply resets and dog rollovers clear it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_cfg <= CLOCK_CFG_RESET;
      end else if (ce_i) begin
         if (supply_reset || dog_roll) begin
            clock_cfg <= CLOCK_CFG_RESET;
         end else if (wr_cfg) begin
            clock_cfg <= wb_dat_i;
         end
      end
   end

   // Active clock mode; a dog reset clears the enable bit but the mode
   // only follows it on the next suspend entry.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_mode <= 1'b0;
      end else if (ce_i) begin
         if (supply_reset) begin
            ext_mode <= 1'b0;
         end else if (running && suspend_req_i) begin
            ext_mode <= clock_cfg[BIT_EXT_OSC_EN];
         end else if (state == ST_OSC_WAIT &&
                      seq_cnt >= resume_limit - 1) begin
            // The new source is used only once its start-up delay is over.
            ext_mode <= ext_mode || clock_cfg[BIT_EXT_OSC_EN];
         end
      end
   end

   // Status register survives every reset except the external one.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_ctrl <= STATUS_RESET;
      end else if (ce_i) begin
         if (wr_status) begin
            status_ctrl <= wb_dat_i & ~({7'h00, 1'b0} |
                                        8'(1 << BIT_SUPPLY_FLAG) |
                                        8'(1 << BIT_DOG_FLAG));
         end
         if (supply_reset) begin
            status_ctrl[BIT_SUPPLY_FLAG] <= 1'b1;
         end
         if (dog_roll) begin
            status_ctrl[BIT_DOG_FLAG] <= 1'b1;
         end
         if (wr_status && !supply_reset) begin
            status_ctrl[BIT_SUPPLY_FLAG] <= status_ctrl[BIT_SUPPLY_FLAG] &
                                            wb_dat_i[BIT_SUPPLY_FLAG];
         end
         if (wr_status && !dog_roll) begin
            status_ctrl[BIT_DOG_FLAG] <= status_ctrl[BIT_DOG_FLAG] &
                                         wb_dat_i[BIT_DOG_FLAG];
         end
      end
   end

   // Sequencer states and the shared delay counter.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_SUPPLY_HOLD;
         seq_cnt <= '0;
      end else if (ce_i) begin
         if (supply_reset) begin
            state <= ST_SUPPLY_HOLD;
            seq_cnt <= '0;
         end else if (dog_roll) begin
            state <= ST_DOG_HOLD;
            seq_cnt <= '0;
         end else begin
            case (state)
               ST_SUPPLY_HOLD: begin
                  state <= ST_STARTUP;
                  seq_cnt <= '0;
               end
               ST_STARTUP: begin
                  if (seq_cnt >= STARTUP_CYC - 1) begin
                     state <= ST_RUN;
                     seq_cnt <= '0;
                  end else begin
                     seq_cnt <= seq_cnt + 32'd1;
                  end
               end
               ST_DOG_HOLD: begin
                  if (seq_cnt >= DOG_HOLD - 1) begin
                     state <= ST_RUN;
                     seq_cnt <= '0;
                  end else begin
                     seq_cnt <= seq_cnt + 32'd1;
                  end
               end
               ST_RUN: begin
                  seq_cnt <= '0;
                  if (suspend_req_i) begin
                     state <= ST_SUSPEND;
                  end else if (!ext_mode && clock_cfg[BIT_EXT_OSC_EN]) begin
                     state <= ST_OSC_WAIT;
                  end
               end
               ST_SUSPEND: begin
                  seq_cnt <= '0;
                  if (wake_event_i) begin
                     state <= ST_OSC_WAIT;
                  end
               end
               ST_OSC_WAIT: begin
                  if (seq_cnt >= resume_limit - 1) begin
                     state <= ST_RUN;
                     seq_cnt <= '0;
                  end else begin
                     seq_cnt <= seq_cnt + 32'd1;
                  end
               end
               default: begin
                  state <= ST_SUPPLY_HOLD;
                  seq_cnt <= '0;
               end
            endcase
         end
      end
   end

   // Dog timer counts only while code runs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dog_cnt <= '0;
      end else if (ce_i) begin
         if (!running || wr_dog || dog_roll) begin
            dog_cnt <= '0;
         end else begin
            dog_cnt <= dog_cnt + 32'd1;
         end
      end
   end

   // Wake timer keeps running in suspend, where it matters most.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_cnt <= '0;
         wake_irq_o <= 1'b0;
      end else if (ce_i) begin
         wake_irq_o <= 1'b0;
         if (!wake_irq_enable_i || wr_cfg) begin
            wake_cnt <= '0;
         end else if (wake_cnt >= wake_limit - 1) begin
            wake_cnt <= '0;
            wake_irq_o <= 1'b1;
         end else begin
            wake_cnt <= wake_cnt + 32'd1;
         end
      end
   end

   assign ext_osc_run_o = ext_mode;
   assign clk_out_disable_o = clock_cfg[BIT_CLK_OUT_DIS];
   assign precision_usb_o = clock_cfg[BIT_PREC_USB];
   assign undervoltage_active_o = uv_enabled;
   assign suspended_o = state == ST_SUSPEND;

   always_comb begin
      core_ctl_o.core_reset = !running && state != ST_SUSPEND &&
                              state != ST_OSC_WAIT;
      core_ctl_o.restart_addr = RESTART_ADDR;
      core_ctl_o.call_stack_pointer = STACK_PTR_RESET;
      core_ctl_o.data_stack_pointer = STACK_PTR_RESET;
      core_ctl_o.pins_tristate = core_ctl_o.core_reset;
      core_ctl_o.irq_disable = core_ctl_o.core_reset;
      core_ctl_o.usb_disable = core_ctl_o.core_reset;
   end
endmodule : crwc_clock_reset_wake

/* crwc_clock_reset_wake_tb.sv */
// Self-checking testbench for the clock, reset and wake controller.
`timescale 1ns/1ps
module crwc_clock_reset_wake_tb;
   import crwc_pkg::*;
   localparam int SU = 20, BW = 8, DG = 50, DH = 10, RL = 12, RS = 6;
   logic clk_i, rst_i, cyc, stb, we, sel, susp, wake, ien, sag, uvt;
   logic uvm, sg, ack, irq, ext, cod, pu, uva, spd;
   logic [7:0] adr, dat, rd, q, v;
   crwc_core_ctl_s cc;
   int errors, n_tests, n;
   int unsigned seed = 52143;
   crwc_clock_reset_wake #(.STARTUP_CYC(SU), .BASE_WAKE(BW), .DOG_CYC(DG),
      .DOG_HOLD(DH), .RES_LONG(RL), .RES_SHORT(RS), .RES_INT(3)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(sel),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
      .undervoltage_i(uvm | uvt), .supply_sag_i(sg), .suspend_req_i(susp),
      .wake_event_i(wake), .wake_irq_enable_i(ien), .wake_irq_o(irq),
      .ext_osc_run_o(ext), .clk_out_disable_o(cod), .precision_usb_o(pu),
      .undervoltage_active_o(uva), .suspended_o(spd), .core_ctl_o(cc));
   crwc_supply_model SUP (.clk_i(clk_i), .sag_req_i(sag),
      .supply_sag_o(sg), .undervoltage_o(uvm));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [7:0] wp(input int k);
      return 8'(BW << k);
   endfunction : wp
   function automatic logic sig(input int s);
      case (s)
         0: return cc.core_reset;
         1: return ext;
         2: return irq;
         default: return spd;
      endcase
   endfunction : sig
   // Counts edges until the chosen output reaches the level; bounded.
   task automatic wait_on(input int s, input logic l, output int c);
      c = 0;
      do begin
         @(posedge clk_i);
         c++;
      end while (sig(s) !== l && c < 300);
   endtask : wait_on
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int t;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      sel <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack !== 1'b1 && t < 20);
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (t >= 20) errors++;
   endtask : wb
   task automatic stop_test();
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      stop_test();
   end
   initial begin
      {cyc, stb, we, sel, susp, wake, ien, sag, uvt} = 9'h000;
      adr = 8'h00;
      dat = 8'h00;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_on(0, 1'b0, n);
      check(8'(n >= SU), 8'h01);
      wb(0, ADDR_CLOCK_CFG, 8'h00);
      check(q, CLOCK_CFG_RESET);
      wb(0, ADDR_STATUS_CTRL, 8'h00);
      check(q, STATUS_RESET);
      wb(0, 8'h40, 8'h00);
      check(q, 8'h00);
      // Firmware keeps undervoltage armed; bit 3 is used only briefly.
      // Firmware moves the data stack later; reset leaves it at zero.
      for (int i = 0; i < 4; i++) begin
         v = 8'(xs()) & 8'h7e;
         wb(1, ADDR_CLOCK_CFG, v);
         wb(0, ADDR_CLOCK_CFG, 8'h00);
         check(q, v);
         check({cod, pu, uva}, {v[1], v[2], ~v[3]});
      end
      for (int k = 0; k < 2; k++) begin
         wb(1, ADDR_WDOG_CLEAR, 8'(xs()));
         wb(1, ADDR_CLOCK_CFG, 8'(k << WAKE_ADJ_LSB));
         ien <= 1'b1;
         wait_on(2, 1'b1, n);
         wait_on(2, 1'b1, n);
         check(8'(n), wp(k));
      end
      ien <= 1'b0;
      wb(1, ADDR_WDOG_CLEAR, 8'h00);
      repeat (40) begin
         @(posedge clk_i);
         check({7'h0, irq}, 8'h00);
      end
      for (int j = 0; j < 2; j++) begin
         wb(1, ADDR_WDOG_CLEAR, 8'h00);
         wb(1, ADDR_CLOCK_CFG, j ? 8'h81 : 8'h01);
         wait_on(1, 1'b1, n);
         check(8'(n + 2 >= (j ? RL : RS) && n <= (j ? RL : RS) + 2), 8'h01);
         sag <= 1'b1;
         @(posedge clk_i);
         sag <= 1'b0;
         wait_on(0, 1'b1, n);
         wait_on(0, 1'b0, n);
         check(8'(n >= SU), 8'h01);
         check({7'h0, ext}, 8'h00);
         wb(0, ADDR_CLOCK_CFG, 8'h00);
         check(q, 8'h00);
         wb(0, ADDR_STATUS_CTRL, 8'h00);
         check(q & 8'h50, 8'h10);
         wb(1, ADDR_STATUS_CTRL, 8'h00);
      end
      wb(1, ADDR_CLOCK_CFG, 8'h01);
      wait_on(1, 1'b1, n);
      wb(1, ADDR_WDOG_CLEAR, 8'h5a);
      wait_on(0, 1'b1, n);
      check(8'(n + 3 >= DG && n <= DG + 3), 8'h01);
      check({7'h0, ext}, 8'h01);
      wait_on(0, 1'b0, n);
      check(8'(n + 1 >= DH && n <= DH + 2), 8'h01);
      wb(0, ADDR_STATUS_CTRL, 8'h00);
      check(q & 8'h40, 8'h40);
      wb(0, ADDR_CLOCK_CFG, 8'h00);
      check(q, 8'h00);
      wb(1, ADDR_WDOG_CLEAR, 8'h00);
      susp <= 1'b1;
      wait_on(3, 1'b1, n);
      susp <= 1'b0;
      uvt <= 1'b1;
      repeat (4) @(posedge clk_i);
      check({uva, cc.core_reset}, 8'h00);
      uvt <= 1'b0;
      wake <= 1'b1;
      wait_on(3, 1'b0, n);
      wake <= 1'b0;
      repeat (8) @(posedge clk_i);
      check({uva, ext}, 8'h02);
      stop_test();
   end
endmodule : crwc_clock_reset_wake_tb

/* crwc_cw_assertions.sv */
// Port checker for the clock, reset and wake controller.
`timescale 1ns/1ps
module crwc_cw_checker
   import crwc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic supply_sag_i,
   input wire logic wake_irq_enable_i,
   input wire logic wake_irq_o,
   input wire logic ext_osc_run_o,
   input wire logic undervoltage_active_o,
   input wire logic suspended_o,
   input wire crwc_core_ctl_s core_ctl_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("bus request not answered in one cycle");
   ack_cause_a: assert property
      ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   reset_pins_a: assert property (
      core_ctl_o.core_reset |-> core_ctl_o.pins_tristate &&
      core_ctl_o.irq_disable && core_ctl_o.usb_disable)
      else $error("pins, interrupts or usb live during reset");
   restart_zero_a: assert property (
      core_ctl_o.core_reset |-> core_ctl_o.restart_addr == 16'h0000 &&
      core_ctl_o.call_stack_pointer == 8'h00 &&
      core_ctl_o.data_stack_pointer == 8'h00)
      else $error("restart address or stack pointer not zero");
   irq_gated_a: assert property (
      wake_irq_o |-> $past(wake_irq_enable_i))
      else $error("wake interrupt while disabled");
   startup_hold_a: assert property (
      $fell(rst_i) |-> core_ctl_o.core_reset [*8])
      else $error("core released too early after power-up");
   suspend_uv_off_a: assert property (
      suspended_o |-> !undervoltage_active_o)
      else $error("undervoltage reset armed in suspend");
   sag_reset_a: assert property (
      supply_sag_i && ce_i |-> ##[0:2] core_ctl_o.core_reset)
      else $error("supply sag did not reset the core");
   sag_clock_a: assert property (
      supply_sag_i && ce_i |-> ##[0:2] !ext_osc_run_o)
      else $error("external oscillator kept after supply reset");
endmodule : crwc_cw_checker

bind crwc_clock_reset_wake crwc_cw_checker u_chk (.clk_i(clk_i),
   .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .supply_sag_i(supply_sag_i),
   .wake_irq_enable_i(wake_irq_enable_i), .wake_irq_o(wake_irq_o),
   .ext_osc_run_o(ext_osc_run_o),
   .undervoltage_active_o(undervoltage_active_o),
   .suspended_o(suspended_o), .core_ctl_o(core_ctl_o));

/* crwc_pkg.sv */
// Package with register map, field layout and timing constants.
package crwc_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam logic [7:0] ADDR_WDOG_CLEAR = 8'h26;
   localparam logic [7:0] ADDR_CLOCK_CFG = 8'hf8;
   localparam logic [7:0] ADDR_STATUS_CTRL = 8'hff;
   localparam logic [7:0] CLOCK_CFG_RESET = 8'h00;
   localparam int unsigned BIT_EXT_OSC_EN = 0;
   localparam int unsigned BIT_CLK_OUT_DIS = 1;
   localparam int unsigned BIT_PREC_USB = 2;
   localparam int unsigned BIT_UV_DISABLE = 3;
   localparam int unsigned WAKE_ADJ_LSB = 4;
   localparam int unsigned BIT_RESUME_LONG = 7;
   localparam int unsigned BIT_SUPPLY_FLAG = 4;
   localparam int unsigned BIT_DOG_FLAG = 6;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] STACK_PTR_RESET = 8'h00;
   localparam logic [15:0] RESTART_ADDR = 16'h0000;
   localparam int unsigned RESUME_LONG_US = 4000;
   localparam int unsigned RESUME_SHORT_US = 128;
   localparam int unsigned RESUME_INT_US = 8;
   localparam int unsigned STARTUP_WAIT_US = 24000;
   localparam int unsigned BASE_WAKE_US = 1000;
   localparam int unsigned DOG_PERIOD_US = 8000;
   localparam int unsigned DOG_HOLD_US = 2000;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
   localparam int unsigned RESUME_LONG_CYC = RESUME_LONG_US * CYC_PER_US;
   localparam int unsigned RESUME_SHORT_CYC = RESUME_SHORT_US * CYC_PER_US;
   localparam int unsigned RESUME_INT_CYC = RESUME_INT_US * CYC_PER_US;
   localparam int unsigned STARTUP_WAIT_CYC = STARTUP_WAIT_US * CYC_PER_US;
   localparam int unsigned BASE_WAKE_CYC = BASE_WAKE_US * CYC_PER_US;
   localparam int unsigned DOG_PERIOD_CYC = DOG_PERIOD_US * CYC_PER_US;
   localparam int unsigned DOG_HOLD_CYC = DOG_HOLD_US * CYC_PER_US;
   typedef enum logic [2:0] {
      ST_SUPPLY_HOLD = 3'b000,
      ST_STARTUP = 3'b001,
      ST_DOG_HOLD = 3'b010,
      ST_RUN = 3'b011,
      ST_SUSPEND = 3'b100,
      ST_OSC_WAIT = 3'b101
   } crwc_state_e;
   typedef struct packed {
      logic core_reset;
      logic [15:0] restart_addr;
      logic [7:0] call_stack_pointer;
      logic [7:0] data_stack_pointer;
      logic pins_tristate;
      logic irq_disable;
      logic usb_disable;
   } crwc_core_ctl_s;
endpackage : crwc_pkg

/* crwc_supply_model.sv */
// Supply model: a sag, then a slow climb past the undervoltage threshold.
`timescale 1ns/1ps
module crwc_supply_model (
   input wire logic clk_i,
   input wire logic sag_req_i,
   output logic supply_sag_o,
   output logic undervoltage_o
);
   logic [3:0] left = 4'h0;
   always_ff @(posedge clk_i) begin
      if (sag_req_i) begin
         left <= 4'hc;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   // Sag clears first; the low level lingers, as a real rail climbs slowly.
   assign supply_sag_o = (left > 4'h6);
   assign undervoltage_o = (left != 4'h0);
endmodule : crwc_supply_model
